// [rtl/dsg_pkg.sv]
// Purpose: shared constants and types for the deep-sleep unit clock gating block
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   run, sleep and deep-sleep gating registers share one layout
//==========================================================================
// package
//==========================================================================
package dsg_pkg;
  // register offsets
  localparam logic [11:0] DSG_RUN_GATE_OFS   = 12'h104;
  localparam logic [11:0] DSG_SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] DSG_DEEP_GATE_OFS  = 12'h124;
  localparam logic [11:0] DSG_RUN_CFG_OFS    = 12'h060;
  // field positions
  localparam int DSG_SEL_BIT = 27;
  localparam int DSG_NUM_UNITS = 12;
  // writable bits of a gating register
  localparam logic [31:0] DSG_GATE_MASK = 32'h030F_5033;
  localparam logic [31:0] DSG_GATE_RST  = 32'h0000_0000;
  localparam logic [31:0] DSG_CFG_MASK  = 32'h0800_0000;
  localparam logic [31:0] DSG_CFG_RST   = 32'h0000_0000;
  // power states
  typedef enum logic [1:0]
  {
    DSG_RUN   = 2'b00,
    DSG_SLEEP = 2'b01,
    DSG_DEEP  = 2'b10
  } dsg_pwr_t;
  // register bus request
  typedef struct packed
  {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dsg_req_t;
  // peripheral access probe: unit index and valid
  typedef struct packed
  {
    logic [3:0] unit;
    logic       valid;
  } dsg_probe_t;
endpackage : dsg_pkg

// [rtl/dsg_clock_gate.sv]
// Purpose: per-unit clock gating for run, sleep and deep-sleep states
// Assumes: single clock clk_sys at 20 MHz, resetn asynchronous active low
// Notes:   unit i maps to gating bit position from a constant table
`timescale 1ns/1ns
//==========================================================================
// gating controller
//==========================================================================
// Functional notes
// - a set gating bit passes the clock to its unit, a clear bit stops and disables it.
// - an access to a unit whose clock is off ends in a bus fault.
// - all gating registers clear to zero at reset so every unit starts off.
// - run, sleep and deep-sleep gating registers exist with the same layout.
// - sleep and deep-sleep registers act only while the gating-select bit is set.
// - bits 25 and 24 gate comparators b and a.
// - bits 19 to 16 gate timers d, c, b and a.
// - bits 14 and 12 gate two-wire units b and a, bits 15 and 13 are reserved.
// - bits 5 and 4 gate sync serial units b and a, bits 3 and 2 are reserved.
// - bits 1 and 0 gate async serial units b and a, reset to zero.
// - reserved bits read as zero and ignore writes.
module dsg_clock_gate
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // register port
  input  wire dsg_req_t                 req,
  output logic [31:0]                   rdata,
  // power state from the core
  input  wire dsg_pwr_t                 pwr_state,
  // peripheral access probe
  input  wire dsg_probe_t               probe,
  output logic                          bus_fault,
  // unit clock enables
  output logic [DSG_NUM_UNITS-1:0]      unit_clk_en
);
  // unit index to register bit position
  localparam int UNIT_BIT [DSG_NUM_UNITS] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};

  logic [31:0] run_gate_q, sleep_gate_q, deep_gate_q, cfg_q;
  logic [31:0] rdata_q, rdata_d;
  logic        fault_q;
  logic [31:0] sel_gate;
  logic [DSG_NUM_UNITS-1:0] en_d, en_q;

  //==========================================================================
  // address decode
  //==========================================================================
  // write strobes per register
  wire wr_run   = req.wr && (req.addr == DSG_RUN_GATE_OFS);
  wire wr_sleep = req.wr && (req.addr == DSG_SLEEP_GATE_OFS);
  wire wr_deep  = req.wr && (req.addr == DSG_DEEP_GATE_OFS);
  wire wr_cfg   = req.wr && (req.addr == DSG_RUN_CFG_OFS);
  wire sel_on   = cfg_q[DSG_SEL_BIT];

  // read mux, unmapped reads give zero
  assign rdata_d = (req.addr == DSG_RUN_GATE_OFS)   ? run_gate_q   :
                   (req.addr == DSG_SLEEP_GATE_OFS) ? sleep_gate_q :
                   (req.addr == DSG_DEEP_GATE_OFS)  ? deep_gate_q  :
                   (req.addr == DSG_RUN_CFG_OFS)    ? cfg_q        : 32'h0000_0000;

  // source register for the current power state
  assign sel_gate = (!sel_on)                 ? run_gate_q   :
                    (pwr_state == DSG_DEEP)   ? deep_gate_q  :
                    (pwr_state == DSG_SLEEP)  ? sleep_gate_q : run_gate_q;

  //==========================================================================
  // registers
  //==========================================================================
  // gating registers, reserved bits masked out
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      run_gate_q   <= DSG_GATE_RST;
      sleep_gate_q <= DSG_GATE_RST;
      deep_gate_q  <= DSG_GATE_RST;
      cfg_q        <= DSG_CFG_RST;
    end
    else
    begin
      if (wr_run)   run_gate_q   <= req.wdata & DSG_GATE_MASK;
      if (wr_sleep) sleep_gate_q <= req.wdata & DSG_GATE_MASK;
      if (wr_deep)  deep_gate_q  <= req.wdata & DSG_GATE_MASK;
      if (wr_cfg)   cfg_q        <= req.wdata & DSG_CFG_MASK;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (req.rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 32'h0000_0000;
  end
  assign rdata = rdata_q;

  //==========================================================================
  // unit enables
  //==========================================================================
  // one enable per unit from its gating bit
  for (genvar i = 0; i < DSG_NUM_UNITS; i++)
  begin : g_unit
    assign en_d[i] = sel_gate[UNIT_BIT[i]];
  end

  // registered enables for glitch-free gating
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      en_q <= '0;
    else
      en_q <= en_d;
  end
  assign unit_clk_en = en_q;

  // fault on access to a unit with its clock off
  wire probe_hit = probe.valid && (probe.unit < 4'(DSG_NUM_UNITS));
  wire probe_off = probe_hit && !en_q[probe.unit];
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      fault_q <= 1'b0;
    else
      fault_q <= probe_off;
  end
  assign bus_fault = fault_q;

  //==========================================================================
  // checks
  //==========================================================================
  sequence s_deep_write;
    wr_deep ##1 1'b1;
  endsequence

  a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    req.rd |=> ((rdata & ~(DSG_GATE_MASK | DSG_CFG_MASK)) == 32'h0000_0000))
    else $error("reserved bits read nonzero");
  a_fault_when_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (probe.valid && probe.unit < 4'(DSG_NUM_UNITS) && !unit_clk_en[probe.unit]) |=> bus_fault)
    else $error("missing bus fault for gated unit");
  a_no_fault_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    (probe.valid && probe.unit < 4'(DSG_NUM_UNITS) && unit_clk_en[probe.unit]) |=> !bus_fault)
    else $error("bus fault for clocked unit");
  a_deep_drives_en: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sel_on && pwr_state == DSG_DEEP) |=> (unit_clk_en[0] == $past(deep_gate_q[0])))
    else $error("deep state enable mismatch");
  a_select_off_run: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!sel_on) |=> (unit_clk_en[11] == $past(run_gate_q[25])))
    else $error("run register not used with select off");
  a_deep_write_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_deep_write |-> (deep_gate_q[19:16] == $past(req.wdata[19:16])))
    else $error("timer bits not stored");
  a_comp_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_run |=> (run_gate_q[25:24] == $past(req.wdata[25:24])))
    else $error("comparator bits not stored");
  a_two_wire_rsv: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_sleep |=> (sleep_gate_q[15] == 1'b0 && sleep_gate_q[13] == 1'b0
                  && sleep_gate_q[14] == $past(req.wdata[14])))
    else $error("two-wire field wrong");
  a_serial_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_deep |=> (deep_gate_q[3:2] == 2'b00 && deep_gate_q[5:4] == $past(req.wdata[5:4])))
    else $error("sync serial field wrong");
  a_async_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_deep |=> (deep_gate_q[1:0] == $past(req.wdata[1:0])))
    else $error("async serial field wrong");
  a_reset_clear: assert property (@(posedge clk_sys)
    $rose(resetn) |-> (deep_gate_q == 32'h0000_0000 && unit_clk_en == '0))
    else $error("state not clear after reset");

  // write to a register, then the cycle that shows its effect
  sequence s_run_write;
    wr_run ##1 1'b1;
  endsequence

  sequence s_sleep_write;
    wr_sleep ##1 1'b1;
  endsequence

  sequence s_cfg_write;
    wr_cfg ##1 1'b1;
  endsequence

  // read path, data one cycle after the strobe and zero otherwise
  a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    !req.rd |=> (rdata == 32'h0000_0000))
    else $error("read data not zero outside a read");

  a_run_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr == DSG_RUN_GATE_OFS) |=> (rdata == $past(run_gate_q)))
    else $error("run register read wrong");

  a_sleep_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr == DSG_SLEEP_GATE_OFS) |=> (rdata == $past(sleep_gate_q)))
    else $error("sleep register read wrong");

  a_deep_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr == DSG_DEEP_GATE_OFS) |=> (rdata == $past(deep_gate_q)))
    else $error("deep register read wrong");

  a_cfg_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr == DSG_RUN_CFG_OFS) |=> (rdata == $past(cfg_q)))
    else $error("config register read wrong");

  a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr != DSG_RUN_GATE_OFS && req.addr != DSG_SLEEP_GATE_OFS
     && req.addr != DSG_DEEP_GATE_OFS && req.addr != DSG_RUN_CFG_OFS)
    |=> (rdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // reserved bits never hold a one
  a_run_rsv_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run_gate_q & ~DSG_GATE_MASK) == 32'h0000_0000)
    else $error("run register reserved bit set");

  a_sleep_rsv_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sleep_gate_q & ~DSG_GATE_MASK) == 32'h0000_0000)
    else $error("sleep register reserved bit set");

  a_deep_rsv_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    (deep_gate_q & ~DSG_GATE_MASK) == 32'h0000_0000)
    else $error("deep register reserved bit set");

  a_cfg_rsv_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cfg_q & ~DSG_CFG_MASK) == 32'h0000_0000)
    else $error("config register stray bit set");

  // registers hold their value without a write
  a_run_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wr_run |=> $stable(run_gate_q))
    else $error("run register changed without write");

  a_sleep_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wr_sleep |=> $stable(sleep_gate_q))
    else $error("sleep register changed without write");

  a_deep_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wr_deep |=> $stable(deep_gate_q))
    else $error("deep register changed without write");

  a_cfg_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wr_cfg |=> $stable(cfg_q))
    else $error("config register changed without write");

  // fields land in the register that was written
  a_run_timer_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_run_write |-> (run_gate_q[19:16] == $past(req.wdata[19:16])))
    else $error("run timer bits not stored");

  a_sleep_comp_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_sleep_write |-> (sleep_gate_q[25:24] == $past(req.wdata[25:24])))
    else $error("sleep comparator bits not stored");

  a_deep_two_wire: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_deep |=> (deep_gate_q[15] == 1'b0 && deep_gate_q[13] == 1'b0
                 && deep_gate_q[12] == $past(req.wdata[12])))
    else $error("deep two-wire field wrong");

  a_sleep_serial_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_sleep_write |-> (sleep_gate_q[5:4] == $past(req.wdata[5:4])))
    else $error("sleep sync serial bits not stored");

  a_sleep_async_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_sleep_write |-> (sleep_gate_q[1:0] == $past(req.wdata[1:0])))
    else $error("sleep async serial bits not stored");

  a_cfg_select_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_cfg_write |-> (sel_on == $past(req.wdata[DSG_SEL_BIT])))
    else $error("select bit not stored");

  // source register picked by power state while select is set
  a_sleep_drives_en: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sel_on && pwr_state == DSG_SLEEP) |=> (unit_clk_en[5] == $past(sleep_gate_q[14])))
    else $error("sleep state enable mismatch");

  a_run_state_en: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sel_on && !(pwr_state inside {DSG_SLEEP, DSG_DEEP}))
    |=> (unit_clk_en[6] == $past(run_gate_q[16])))
    else $error("run state enable mismatch");

  // fault only answers a probe to a known unit
  a_fault_needs_probe: assert property (@(posedge clk_sys) disable iff (!resetn)
    !probe.valid |=> !bus_fault)
    else $error("bus fault without access");

  a_fault_bad_index: assert property (@(posedge clk_sys) disable iff (!resetn)
    (probe.valid && probe.unit >= 4'(DSG_NUM_UNITS)) |=> !bus_fault)
    else $error("bus fault for unknown unit");

  // every enable follows its gating bit one cycle later
  for (genvar i = 0; i < DSG_NUM_UNITS; i++)
  begin : g_unit_chk
    a_unit_en_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> (unit_clk_en[i] == $past(sel_gate[UNIT_BIT[i]])))
      else $error("unit enable does not follow its bit");
  end
endmodule : dsg_clock_gate

// [verification/dsg_unit_model.sv]
// Purpose: peripheral-side model that issues unit accesses to the gate
// Assumes: one access pulse for each request from the bench
// Notes:   reaches enabled and disabled units alike so faults show
`timescale 1ns/1ns
//==========================================================================
// unit access model
//==========================================================================
module dsg_unit_model
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // request from bench
  input  wire logic       go,
  input  wire logic [3:0] unit,
  // access probe to the gate
  output dsg_probe_t      probe
);
  // one-cycle access pulse, index inverted while idle
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      probe <= '0;
    else
      probe <= '{unit: go ? unit : ~unit, valid: go};
endmodule : dsg_unit_model

// [verification/tb.sv]
// Purpose: self-checking bench for the deep-sleep gating block
// Assumes: 50 ns clock, reset held 12 cycles
// Notes:   random patterns with fixed corner words
`timescale 1ns/1ns
//==========================================================================
// bench top
//==========================================================================
module tb
  import dsg_pkg::*;
;
  logic                     clk_sys = 0;
  logic                     resetn = 0;
  dsg_req_t                 req = '0;
  dsg_pwr_t                 pwr_state = DSG_RUN;
  logic                     go = 0;
  logic [3:0]               unit = '0;
  dsg_probe_t               probe;
  logic [31:0]              rdata, v, ex;
  logic [31:0]              rg [3];
  logic                     bus_fault;
  logic [DSG_NUM_UNITS-1:0] unit_clk_en;
  int                       miscompares = 0;
  int                       samples_checked = 0;
  int                       pos [12] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
  // clock
  always #25 clk_sys = ~clk_sys;
  dsg_clock_gate i_dut (.clk_sys(clk_sys), .resetn(resetn), .req(req), .rdata(rdata),
    .pwr_state(pwr_state), .probe(probe), .bus_fault(bus_fault), .unit_clk_en(unit_clk_en));
  dsg_unit_model i_units (.clk_sys(clk_sys), .resetn(resetn), .go(go), .unit(unit),
    .probe(probe));
  // expected enables from a gating word
  function automatic logic [31:0] en_of(logic [31:0] r);
    en_of = '0;
    for (int i = 0; i < 12; i++)
      en_of[i] = r[pos[i]];
  endfunction : en_of
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) req <= '0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(posedge clk_sys) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) req <= '0;
    @(negedge clk_sys) chk("rdata", e, rdata);
  endtask : rd
  task automatic prb(int u);
    @(posedge clk_sys) go <= 1'b1;
    unit <= 4'(u);
    @(posedge clk_sys) go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys) chk("bus_fault", {31'h0, ~ex[u]}, {31'h0, bus_fault});
  endtask : prb
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // watchdog
  initial
  begin
    #(50 * 5000);
    miscompares++;
    summarize();
  end
  // main sequence
  initial
  begin
    v = $urandom(59273);
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(DSG_DEEP_GATE_OFS, DSG_GATE_RST);
    rd(DSG_RUN_GATE_OFS, DSG_GATE_RST);
    rd(DSG_RUN_CFG_OFS, DSG_CFG_RST);
    chk("unit_clk_en", 32'h0, 32'(unit_clk_en));
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
      wr(DSG_DEEP_GATE_OFS, v);
      rd(DSG_DEEP_GATE_OFS, v & DSG_GATE_MASK);
    end
    wr(12'hFFC, 32'hFFFF_FFFF);
    rd(12'hFFC, 32'h0);
    $display("readback test done");
    for (int p = 0; p < 3; p++)
    begin
      rg[p] = $urandom & DSG_GATE_MASK;
      wr(p == 0 ? DSG_RUN_GATE_OFS : p == 1 ? DSG_SLEEP_GATE_OFS : DSG_DEEP_GATE_OFS, rg[p]);
    end
    for (int s = 0; s < 2; s++)
    begin
      wr(DSG_RUN_CFG_OFS, s ? 32'hFFFF_FFFF : 32'h0);
      rd(DSG_RUN_CFG_OFS, s ? DSG_CFG_MASK : 32'h0);
      for (int p = 0; p < 3; p++)
      begin
        @(posedge clk_sys) pwr_state <= dsg_pwr_t'(2'(p));
        repeat (3) @(posedge clk_sys);
        ex = en_of(s ? rg[p] : rg[0]);
        @(negedge clk_sys) chk("unit_clk_en", ex, 32'(unit_clk_en));
        for (int u = 0; u < 12; u++)
          prb(u);
      end
    end
    $display("selection test done");
    @(posedge clk_sys) resetn <= 1'b0;
    @(posedge clk_sys) resetn <= 1'b1;
    rd(DSG_DEEP_GATE_OFS, 32'h0);
    chk("unit_clk_en", 32'h0, 32'(unit_clk_en));
    $display("second reset test done");
    summarize();
  end
endmodule : tb
